// File: design/dmr_mode_reg0.sv
// dmr_mode_reg0: memory-side init tracking and mode register 0 of a DDR3 device.
// Assumes command pins are launched by the controller on the CK clock (ckClk);
// mclk is the device's internal clock, unrelated in phase.
//
// Operation
// - after reset release 500 us pass before clock enable rises.
// - termination stays off during reset until clock enable first registered high.
// - mode sets spaced by cycle time; only NOP or deselect until delay.
// - all command strobes and bank bits low writes mode register 0.
// - burst size field decodes fixed 8, on the fly, chop 4, reserved.
// - read latency code with low bit selects 5..11 or 12..16.
// - DLL reset bit high starts DLL reset; low leaves DLL alone.
// - write recovery field decodes to 16,5,6,7,8,10,12,14 cycles.
// - register 0 holds burst, order, latency, test, DLL, recovery, powerdown.
// - burst order bit zero sequential, one interleaved.
// - DLL reset bit clears itself once the reset is carried out.
// - powerdown bit zero freezes DLL, one keeps it running.
`timescale 1ns/1ps

module dmr_mode_reg0
    import dmr_pkg::*;
#(
    parameter int INIT_WAIT_CYCLES = INIT_CYCLES,
    parameter int MRD_CYCLES       = MODE_SET_CYCLES,
    parameter int MOD_CYCLES       = MODE_OTHER_CYCLES,
    parameter int XPR_CYCLES       = RESET_EXIT_CYCLES,
    parameter int DLLK_CYCLES      = DLL_LOCK_CYCLES
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              ckClk,
    input  wire logic              clockEnable,
    input  wire logic              chipSel_b,
    input  wire logic              rowStrobe_b,
    input  wire logic              colStrobe_b,
    input  wire logic              writeEnable_b,
    input  wire logic [2:0]        bankAddr,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              terminationControl,
    output logic                   initDone,
    output logic [1:0]             burstSizeField,
    output logic                   burstReserved,
    output logic                   burstOrderSelect,
    output logic [4:0]             readLatencyField,
    output logic                   latencyReserved,
    output logic                   factoryTestSelect,
    output logic                   dllResetBit,
    output logic                   dllLocked,
    output logic [4:0]             writeRecovery,
    output logic                   powerdownDllKeep,
    output logic                   mr0Written,
    output logic                   terminationOn,
    output logic                   timingViolation
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (INIT_WAIT_CYCLES < 1 || INIT_WAIT_CYCLES >= (1 << INIT_CNT_W))
        $error("init wait count out of range");
    if (MRD_CYCLES < 1 || MOD_CYCLES < MRD_CYCLES || MOD_CYCLES >= (1 << GAP_W) - 1)
        $error("mode set spacing out of range");
    if (XPR_CYCLES < 1 || XPR_CYCLES >= (1 << GAP_W) - 1)
        $error("reset exit count out of range");
    if (DLLK_CYCLES < 1 || DLLK_CYCLES >= (1 << DLL_CNT_W))
        $error("dll lock count out of range");

    localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_WAIT_CYCLES - 1);
    localparam logic [GAP_W-1:0]      GAP_MRD   = GAP_W'(MRD_CYCLES);
    localparam logic [GAP_W-1:0]      GAP_MOD   = GAP_W'(MOD_CYCLES);
    localparam logic [GAP_W-1:0]      GAP_XPR   = GAP_W'(XPR_CYCLES);
    localparam logic [GAP_W-1:0]      GAP_MAX   = '1;
    localparam logic [DLL_CNT_W-1:0]  DLL_LAST  = DLL_CNT_W'(DLLK_CYCLES - 1);

    // ------------------------------------------------------------------
    // field decoders
    // ------------------------------------------------------------------
    // latency code {A6,A5,A4,A2}; zero marks a reserved code
    function automatic logic [4:0] dmr_latency(input logic [2:0] code, input logic lowBit);
        logic [4:0] cyc;
        cyc = 5'h00;
        if (!lowBit && code != 3'h0)
            cyc = 5'h04 + {2'h0, code};
        else if (lowBit && code <= 3'h4)
            cyc = 5'h0C + {2'h0, code};
        return cyc;
    endfunction

    function automatic logic [4:0] dmr_wrec(input logic [2:0] code);
        logic [4:0] cyc;
        cyc = 5'h10;
        case (code)
            3'h0: cyc = 5'h10;
            3'h1: cyc = 5'h05;
            3'h2: cyc = 5'h06;
            3'h3: cyc = 5'h07;
            3'h4: cyc = 5'h08;
            3'h5: cyc = 5'h0A;
            3'h6: cyc = 5'h0C;
            default: cyc = 5'h0E;
        endcase
        return cyc;
    endfunction

    // ------------------------------------------------------------------
    // internal clock domain: init wait counted on mclk after reset release
    // ------------------------------------------------------------------
    dmr_core_t core_r;
    dmr_core_t core_nxt;

    // the wait runs on mclk so it needs no CK edges
    always_comb begin
        core_nxt = core_r;
        if (!core_r.initDone) begin
            if (core_r.initCnt == INIT_LAST)
                core_nxt.initDone = 1'b1;
            else
                core_nxt.initCnt = core_r.initCnt + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            core_r <= '0;
        else
            core_r <= core_nxt;
    end

    // ------------------------------------------------------------------
    // link clock domain: command decode and mode register 0
    // ------------------------------------------------------------------
    dmr_link_t link_r;
    dmr_link_t link_nxt;

    logic cmdActive;
    logic cmdNop;
    logic cmdMrs;
    logic cmdOther;

    // deselect is chip select high; NOP is all strobes high
    assign cmdActive = !chipSel_b;
    assign cmdNop    = cmdActive && rowStrobe_b && colStrobe_b && writeEnable_b;
    assign cmdMrs    = cmdActive && !rowStrobe_b && !colStrobe_b && !writeEnable_b;
    assign cmdOther  = cmdActive && !cmdNop && !cmdMrs;

    always_comb begin
        link_nxt = link_r;
        // init done is a level, two flops across
        link_nxt.initSync1 = core_r.initDone;
        link_nxt.initSync2 = link_r.initSync1;

        // gap counters saturate so an idle link never wraps into a false hit
        if (link_r.mrsGap != GAP_MAX)
            link_nxt.mrsGap = link_r.mrsGap + 1'b1;
        if (link_r.ckeSeen && link_r.exitCnt != GAP_MAX)
            link_nxt.exitCnt = link_r.exitCnt + 1'b1;

        if (clockEnable) begin
            link_nxt.ckeSeen = 1'b1;
            if (!link_r.initSync2)
                link_nxt.violation = 1'b1;
        end

        // termination off until clock enable has been registered high
        link_nxt.termEnable = link_nxt.ckeSeen && terminationControl;

        if (cmdMrs) begin
            link_nxt.mrsGap = '0;
            if (link_r.mrsGap < GAP_MRD || !link_r.ckeSeen || link_r.exitCnt < GAP_XPR)
                link_nxt.violation = 1'b1;
        end
        if (cmdOther && link_r.mrsGap < GAP_MOD)
            link_nxt.violation = 1'b1;

        // DLL reset: counts lock time, bit drops once the reset is under way
        if (link_r.dllResetBit) begin
            link_nxt.dllResetBit = 1'b0;
            link_nxt.dllCnt      = '0;
        end else if (!link_r.dllLocked) begin
            if (link_r.dllCnt == DLL_LAST)
                link_nxt.dllLocked = 1'b1;
            else
                link_nxt.dllCnt = link_r.dllCnt + 1'b1;
        end

        if (cmdMrs && bankAddr == MR0_SELECT) begin
            link_nxt.mr0Written        = 1'b1;
            link_nxt.burstSizeField    = addr[BURST_SIZE_LSB +: 2];
            link_nxt.burstReserved     = addr[BURST_SIZE_LSB +: 2] == BURST_RSVD;
            link_nxt.burstOrderSelect  = addr[BURST_ORDER_BIT];
            link_nxt.readLatency       = dmr_latency(addr[LATENCY_CODE_LSB +: 3],
                                                     addr[LATENCY_LOW_BIT]);
            link_nxt.latencyReserved   = dmr_latency(addr[LATENCY_CODE_LSB +: 3],
                                                     addr[LATENCY_LOW_BIT]) == 5'h00;
            link_nxt.factoryTestSelect = addr[FACTORY_TEST_BIT];
            link_nxt.writeRecovery     = dmr_wrec(addr[WRITE_REC_LSB +: 3]);
            link_nxt.powerdownDllKeep  = addr[POWERDOWN_KEEP_BIT];
            if (addr[DLL_RESET_BIT]) begin
                link_nxt.dllResetBit = 1'b1;
                link_nxt.dllLocked   = 1'b0;
            end
        end
    end

    // the reset pin is asynchronous; the link clock may stand still under it
    always_ff @(posedge ckClk or negedge rst_b) begin
        if (!rst_b) begin
            link_r                <= '0;
            link_r.readLatency    <= LATENCY_RESET;
            link_r.writeRecovery  <= WREC_RESET;
            link_r.burstSizeField <= BURST_FIXED8;
            link_r.mrsGap         <= GAP_MAX;
        end else begin
            link_r <= link_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------------
    assign initDone          = core_r.initDone;
    assign burstSizeField    = link_r.burstSizeField;
    assign burstReserved     = link_r.burstReserved;
    assign burstOrderSelect  = link_r.burstOrderSelect;
    assign readLatencyField  = link_r.readLatency;
    assign latencyReserved   = link_r.latencyReserved;
    assign factoryTestSelect = link_r.factoryTestSelect;
    assign dllResetBit       = link_r.dllResetBit;
    assign dllLocked         = link_r.dllLocked;
    assign writeRecovery     = link_r.writeRecovery;
    assign powerdownDllKeep  = link_r.powerdownDllKeep;
    assign mr0Written        = link_r.mr0Written;
    assign terminationOn     = link_r.termEnable;
    assign timingViolation   = link_r.violation;

endmodule // dmr_mode_reg0

// File: inc/dmr_pkg.sv
// dmr_pkg: constants and state types for the memory-side mode register 0 block.
// Assumes a 10 MHz internal clock and commands sampled on the link clock.
package dmr_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int MCLK_PERIOD_NS     = 100;
    localparam int INIT_TIME_US       = 500;
    // least time, rounded up to whole cycles
    localparam int INIT_CYCLES        =
        (INIT_TIME_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int INIT_CNT_W         = 13;
    // link-side counts in CK cycles; no figure is printed, plain defaults
    localparam int MODE_SET_CYCLES    = 4;
    localparam int MODE_OTHER_CYCLES  = 12;
    localparam int RESET_EXIT_CYCLES  = 5;
    localparam int DLL_LOCK_CYCLES    = 512;
    localparam int GAP_W              = 8;
    localparam int DLL_CNT_W          = 10;

    // ------------------------------------------------------------------
    // command pins and mode register 0 field positions
    // ------------------------------------------------------------------
    localparam int          ADDR_W     = 14;
    localparam logic [2:0]  MR0_SELECT = 3'h0;
    localparam int BURST_SIZE_LSB      = 0;
    localparam int LATENCY_LOW_BIT     = 2;
    localparam int BURST_ORDER_BIT     = 3;
    localparam int LATENCY_CODE_LSB    = 4;
    localparam int FACTORY_TEST_BIT    = 7;
    localparam int DLL_RESET_BIT       = 8;
    localparam int WRITE_REC_LSB       = 9;
    localparam int POWERDOWN_KEEP_BIT  = 12;

    // burst size field encodings
    localparam logic [1:0] BURST_FIXED8  = 2'h0;
    localparam logic [1:0] BURST_ON_FLY  = 2'h1;
    localparam logic [1:0] BURST_CHOP4   = 2'h2;
    localparam logic [1:0] BURST_RSVD    = 2'h3;

    // reset values of held state
    localparam logic [4:0] LATENCY_RESET = 5'h00;
    localparam logic [4:0] WREC_RESET    = 5'h00;

    // ------------------------------------------------------------------
    // state types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [INIT_CNT_W-1:0] initCnt;
        logic                  initDone;
    } dmr_core_t;

    typedef struct packed {
        logic                 initSync1;
        logic                 initSync2;
        logic                 ckeSeen;
        logic [1:0]           burstSizeField;
        logic                 burstReserved;
        logic                 burstOrderSelect;
        logic [4:0]           readLatency;
        logic                 latencyReserved;
        logic                 factoryTestSelect;
        logic                 dllResetBit;
        logic [4:0]           writeRecovery;
        logic                 powerdownDllKeep;
        logic                 mr0Written;
        logic [DLL_CNT_W-1:0] dllCnt;
        logic                 dllLocked;
        logic [GAP_W-1:0]     mrsGap;
        logic [GAP_W-1:0]     exitCnt;
        logic                 violation;
        logic                 termEnable;
    } dmr_link_t;

endpackage

// File: testbench/dmr_ctrl_model.sv
// dmr_ctrl_model: controller side driving clock enable, termination and commands
// assumes a free-running ckClk; the bench calls its tasks
`timescale 1ns/1ps
module dmr_ctrl_model
    import dmr_pkg::*;
(
    input  wire logic              ckClk,
    output logic                   clockEnable,
    output logic                   chipSel_b,
    output logic                   rowStrobe_b,
    output logic                   colStrobe_b,
    output logic                   writeEnable_b,
    output logic [2:0]             bankAddr,
    output logic [ADDR_W-1:0]      addr,
    output logic                   terminationControl
);
    // power-up state: cke low and deselected long before reset ends
    initial begin
        clockEnable        = 1'b0;
        terminationControl = 1'b0;
        {chipSel_b, rowStrobe_b, colStrobe_b, writeEnable_b} = 4'hF;
        bankAddr = 3'h0;
        addr     = 14'h0000;
    end

    // deselect; released lines toggle so nothing stale looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ckClk);
            chipSel_b <= 1'b1;
            {rowStrobe_b, colStrobe_b, writeEnable_b} <= ~{rowStrobe_b, colStrobe_b, writeEnable_b};
            bankAddr <= ~bankAddr;
            addr     <= ~addr;
        end
    endtask

    // one mode set, then only deselects for gap edges
    task automatic mrs(input logic [2:0] ba, input logic [ADDR_W-1:0] a, input int gap);
        @(posedge ckClk);
        {chipSel_b, rowStrobe_b, colStrobe_b, writeEnable_b} <= 4'h0;
        bankAddr <= ba;
        addr     <= {1'b0, a[ADDR_W-2:0]};
        idle(gap);
    endtask

    // long calibration: cs and we low, ras and cas high, A10 high
    task automatic zqcl(input int gap);
        @(posedge ckClk);
        {chipSel_b, rowStrobe_b, colStrobe_b, writeEnable_b} <= 4'h6;
        addr[10] <= 1'b1;
        idle(gap);
    endtask

    // cke and termination held static between calls
    task automatic pins(input logic ce, input logic term);
        @(posedge ckClk);
        clockEnable        <= ce;
        terminationControl <= term;
    endtask
endmodule // dmr_ctrl_model

// File: testbench/dmr_mode_reg0_chk.sv
// checker: decode and timing relations at the mode register 0 block ports
// assumes binding onto dmr_mode_reg0, init count handed on from the instance
`timescale 1ns/1ps
module dmr_mode_reg0_chk
    import dmr_pkg::*;
#(parameter int INIT_WAIT_CYCLES = INIT_CYCLES) (
    input wire logic              mclk,
    input wire logic              rst_b,
    input wire logic              ckClk,
    input wire logic              clockEnable,
    input wire logic              chipSel_b,
    input wire logic              rowStrobe_b,
    input wire logic              colStrobe_b,
    input wire logic              writeEnable_b,
    input wire logic [2:0]        bankAddr,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              terminationControl,
    input wire logic              initDone,
    input wire logic [1:0]        burstSizeField,
    input wire logic              burstReserved,
    input wire logic              burstOrderSelect,
    input wire logic [4:0]        readLatencyField,
    input wire logic              latencyReserved,
    input wire logic              factoryTestSelect,
    input wire logic              dllResetBit,
    input wire logic              dllLocked,
    input wire logic [4:0]        writeRecovery,
    input wire logic              powerdownDllKeep,
    input wire logic              terminationOn,
    input wire logic              timingViolation
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic     ckeSeen_r;
    int       initCnt_r;
    wire      mrsAny = !chipSel_b && !rowStrobe_b && !colStrobe_b && !writeEnable_b;
    wire      mrs0   = mrsAny && bankAddr == MR0_SELECT;
    wire [4:0] lc    = 5'(addr[6:4]);
    wire [4:0] wc    = 5'(addr[11:9]);
    // expected decodes; zero latency marks a reserved code
    wire [4:0] latExp = addr[2] ? (lc <= 5'h04 ? lc + 5'h0C : 5'h00)
                                : (lc != 5'h00 ? lc + 5'h04 : 5'h00);
    wire [4:0] wrExp  = wc == 5'h00 ? 5'h10 : (wc < 5'h04 ? wc + 5'h04 : wc << 1);

    // cke registered high since reset
    always_ff @(posedge ckClk or negedge rst_b) begin
        if (!rst_b)
            ckeSeen_r <= 1'b0;
        else if (clockEnable)
            ckeSeen_r <= 1'b1;
    end

    // mclk edges since release, saturating so it never wraps
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            initCnt_r <= 0;
        else if (initCnt_r < INIT_WAIT_CYCLES + 4)
            initCnt_r <= initCnt_r + 1;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_mode_bits: assert property (@(posedge ckClk) disable iff (!rst_b)
        mrs0 |=> burstOrderSelect == $past(addr[3]) && factoryTestSelect == $past(addr[7])
            && powerdownDllKeep == $past(addr[12])) else $error("mode bits not loaded");
    a_burst_size: assert property (@(posedge ckClk) disable iff (!rst_b)
        mrs0 |=> burstSizeField == $past(addr[1:0])
            && burstReserved == ($past(addr[1:0]) == 2'h3)) else $error("burst field wrong");
    a_latency_map: assert property (@(posedge ckClk) disable iff (!rst_b)
        mrs0 |=> readLatencyField == $past(latExp)
            && latencyReserved == ($past(latExp) == 5'h00)) else $error("latency wrong");
    a_wrec_map: assert property (@(posedge ckClk) disable iff (!rst_b)
        mrs0 |=> writeRecovery == $past(wrExp)) else $error("write recovery wrong");
    a_dll_pulse: assert property (@(posedge ckClk) disable iff (!rst_b)
        mrs0 && addr[8] |=> dllResetBit && !dllLocked ##1 (!dllResetBit && !dllLocked)[*7])
        else $error("dll reset pulse wrong");
    a_dll_quiet: assert property (@(posedge ckClk) disable iff (!rst_b)
        mrs0 && !addr[8] |=> !dllResetBit) else $error("dll reset without request");
    a_term_off: assert property (@(posedge ckClk) disable iff (!rst_b)
        !ckeSeen_r |-> !terminationOn) else $error("termination on before cke");
    a_term_follow: assert property (@(posedge ckClk) disable iff (!rst_b)
        ckeSeen_r |=> terminationOn == $past(terminationControl)) else $error("term lag");
    a_mrs_gap: assert property (@(posedge ckClk) disable iff (!rst_b)
        mrsAny ##2 mrsAny |=> timingViolation) else $error("close mode sets not flagged");
    a_init_wait: assert property (@(posedge mclk) disable iff (!rst_b)
        initCnt_r < INIT_WAIT_CYCLES |-> !initDone) else $error("init ended early");
    a_init_ends: assert property (@(posedge mclk) disable iff (!rst_b)
        initCnt_r == INIT_WAIT_CYCLES + 3 |-> initDone) else $error("init never ended");
endmodule // dmr_mode_reg0_chk

// File: testbench/dmr_mode_reg0_tb.sv
// dmr_mode_reg0_tb: self-checking bench for the mode register 0 block
// assumes shortened init and lock counts; the controller model drives the pins
`timescale 1ns/1ps
module dmr_mode_reg0_tb;
    import dmr_pkg::*;
    localparam int INIT_SIM = 20;
    localparam int DLLK_SIM = 16;
    logic mclk  = 1'b0;
    logic ckClk = 1'b0;
    logic rst_b = 1'b0;
    wire  clockEnable, chipSel_b, rowStrobe_b, colStrobe_b, writeEnable_b, terminationControl;
    wire  [2:0] bankAddr;
    wire  [ADDR_W-1:0] addr;
    logic initDone, burstReserved, burstOrderSelect, latencyReserved, factoryTestSelect;
    logic dllResetBit, dllLocked, powerdownDllKeep, mr0Written, terminationOn, timingViolation;
    logic [1:0] burstSizeField;
    logic [4:0] readLatencyField, writeRecovery;
    int   bad_count = 0;
    int   total_checks = 0;
    integer seed = 19;
    int   n;
    logic [ADDR_W-1:0] a;

    // half periods of 50 and 24 ns never meet on a common rising edge
    always #50 mclk = ~mclk;
    always #24 ckClk = ~ckClk;

    dmr_mode_reg0 #(.INIT_WAIT_CYCLES(INIT_SIM), .DLLK_CYCLES(DLLK_SIM)) dmr_mode_reg0_i (.*);
    dmr_ctrl_model ctl_i (.*);

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // reference decode of one register 0 word, kept in plain integers
    task automatic check_mr0(input logic [ADDR_W-1:0] w);
        int c;
        int lat;
        int wr;
        c   = w[6:4];
        lat = w[2] ? (c <= 4 ? c + 12 : 0) : (c != 0 ? c + 4 : 0);
        c   = w[11:9];
        wr  = c == 0 ? 16 : (c < 4 ? c + 4 : 2 * c);
        chk("burstSize", 16'(burstSizeField), 16'(w[1:0]));
        chk("burstRsvd", 16'(burstReserved), 16'(w[1:0] == 2'h3));
        chk("order", 16'(burstOrderSelect), 16'(w[3]));
        chk("latency", 16'(readLatencyField), 16'(lat));
        chk("latRsvd", 16'(latencyReserved), 16'(lat == 0));
        chk("testSel", 16'(factoryTestSelect), 16'(w[7]));
        chk("wrRec", 16'(writeRecovery), 16'(wr));
        chk("pdKeep", 16'(powerdownDllKeep), 16'(w[12]));
        chk("written", 16'(mr0Written), 16'h0001);
    endtask

    // main sequence: power-up, mode sets, decode sweep, spacing fault, warm reset
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        ctl_i.pins(1'b0, 1'b1);
        for (n = 0; n < 60 && initDone !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
            chk("termOff", 16'(terminationOn), 16'h0000);
        end
        chk("initWait", 16'(n >= INIT_SIM && n <= INIT_SIM + 2), 16'h0001);
        if (n == 60)
            close_out();
        ctl_i.idle(6);
        // nominal termination left off, so the control may stand high
        ctl_i.pins(1'b1, 1'b1);
        ctl_i.idle(8);
        #1;
        chk("termOn", 16'(terminationOn), 16'h0001);
        ctl_i.mrs(3'h2, 14'h0FFF, 12);
        ctl_i.mrs(3'h3, 14'h0FFF, 12);
        ctl_i.mrs(3'h1, 14'h0FFE, 12);
        #1;
        chk("notMr0", 16'(mr0Written), 16'h0000);
        ctl_i.mrs(3'h0, 14'h1534, 1);
        #1;
        check_mr0(14'h1534);
        chk("dllPulse", 16'({dllResetBit, dllLocked}), 16'h0002);
        ctl_i.idle(1);
        #1;
        chk("dllClear", 16'(dllResetBit), 16'h0000);
        for (n = 0; n < 40 && dllLocked !== 1'b1; n++) begin
            ctl_i.idle(1);
            #1;
        end
        chk("lockTime", 16'(n >= DLLK_SIM - 1 && n <= DLLK_SIM + 1), 16'h0001);
        if (n == 40)
            close_out();
        ctl_i.zqcl(12);
        // sweep every latency code, burst code and recovery code
        for (int i = 0; i < 16; i++) begin
            a = 14'($random(seed));
            a[8] = 1'b0;
            a[7] = 1'b0;
            {a[6:4], a[2]} = 4'(i);
            a[1:0] = 2'(i);
            a[11:9] = 3'(i + 3);
            ctl_i.mrs(3'h0, a, 12);
            #1;
            check_mr0({1'b0, a[12:0]});
            chk("dllQuiet", 16'(dllLocked), 16'h0001);
        end
        chk("noViol", 16'(timingViolation), 16'h0000);
        ctl_i.mrs(3'h2, 14'h0000, 1);
        ctl_i.mrs(3'h2, 14'h0000, 1);
        #1;
        chk("gapViol", 16'(timingViolation), 16'h0001);
        ctl_i.pins(1'b0, 1'b1);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("rstState", 16'({timingViolation, mr0Written, terminationOn, initDone}),
            16'h0000);
        @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ckClk);
        #1;
        chk("termOff2", 16'(terminationOn), 16'h0000);
        // power-up steps again, then a command too soon after a mode set
        for (n = 0; n < 60 && initDone !== 1'b1; n++)
            @(posedge mclk);
        chk("initWait2", 16'(n < 60), 16'h0001);
        ctl_i.idle(6);
        ctl_i.pins(1'b1, 1'b0);
        ctl_i.idle(8);
        ctl_i.mrs(3'h2, 14'h0000, 1);
        #1;
        chk("noViol2", 16'(timingViolation), 16'h0000);
        ctl_i.zqcl(1);
        #1;
        chk("modViol", 16'(timingViolation), 16'h0001);
        close_out();
    end
endmodule // dmr_mode_reg0_tb

bind dmr_mode_reg0 dmr_mode_reg0_chk #(.INIT_WAIT_CYCLES(INIT_WAIT_CYCLES)) dmr_mode_reg0_chk_i (.*);
